// File: design/modem_irq_pkg.sv
// package for the modem status and interrupt enable register bank
// assumes a 32-bit apb slave port with byte addresses, one register per word
package modem_irq_pkg;

  // register byte addresses
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h00;
  localparam logic [7:0] MODEM_STATUS_OFS = 8'h04;
  localparam logic [7:0] ENH_FEATURE_OFS = 8'h08;
  localparam logic [7:0] MODEM_CONTROL_OFS = 8'h0c;
  localparam logic [7:0] PIN_FUNCTION_OFS = 8'h10;
  localparam logic [7:0] EVENT_STATUS_OFS = 8'h14;

  // reset values
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] ENH_FEATURE_RST = 8'h00;
  localparam logic [7:0] MODEM_CONTROL_RST = 8'h00;
  localparam logic [7:0] PIN_FUNCTION_RST = 8'h00;

  // modem status fields
  localparam int MS_CD = 7;
  localparam int MS_RI = 6;
  localparam int MS_DSR = 5;
  localparam int MS_CTS = 4;
  localparam int MS_DCD = 3;
  localparam int MS_DRI = 2;
  localparam int MS_DDSR = 1;
  localparam int MS_DCTS = 0;

  // interrupt enable fields
  localparam int IE_CTS = 7;
  localparam int IE_RTS = 6;
  localparam int IE_XOFF = 5;
  localparam int IE_SLEEP = 4;
  localparam int IE_MODEM = 3;
  localparam int IE_LINE = 2;
  localparam int IE_TXH = 1;
  localparam int IE_RXH = 0;
  localparam logic [7:0] IE_PROTECTED_MASK = 8'hf0;

  // enhanced feature, modem control and pin function fields
  localparam int EF_WRITE_EN = 4;
  localparam logic [7:0] MC_PROTECTED_MASK = 8'he4;
  localparam int MC_LOOPBACK = 4;
  localparam int MC_RTS = 1;
  localparam int MC_DTR = 0;
  localparam int PF_MODEM_HI = 2;
  localparam int PF_MODEM_LO = 1;

  // event status fields (read clears)
  localparam int EV_XOFF = 0;
  localparam int EV_CTS_RISE = 1;
  localparam int EV_RTS_RISE = 2;

  // modem input line vector order: cd, ri, dsr, cts
  localparam int LN_CD = 3;
  localparam int LN_RI = 2;
  localparam int LN_DSR = 1;
  localparam int LN_CTS = 0;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] line_prev;
    logic [3:0] delta;
    logic [7:0] interrupt_enables;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] pfs;
    logic [2:0] evt;
    logic cts_prev;
    logic rts_prev;
    logic tx_low_prev;
    logic thr_pend;
    logic irq_n;
    logic [31:0] prdata;
    logic pslverr;
  } bank_state_t;

endpackage

// File: design/modem_status_irq_enable.sv
// modem status register, interrupt enable register and the control bits they depend on
// assumes an apb master on CLK_I and active-low modem lines from pins outside the clock domain
//
// Notes on behaviour
// (R1) status bit 7 shows inverted cd pin
// (R2) status bit 6 shows inverted ri pin
// (R3) status bit 5 shows inverted dsr pin
// (R4) status bit 4 shows inverted cts, or the rts control bit in loopback
// (R5) modem status, not pin levels, is valid
// (R6) cd, dsr, cts changes set read-cleared flags
// (R7) ri flag sets only on pin rising
// (R8) irq asserts for any enabled interrupt
// (R9) bits 7,6 enable cts, rts rise interrupts
// (R10) bit 5 enables xoff or special interrupt
// (R11) bit 4 enables sleep mode
// (R12) bit 3 enables modem status interrupt
// (R13) bit 2 enables line status interrupt
// (R14) bit 1 enables transmit holding interrupt
// (R15) bit 0 enables receive holding interrupt
// (R16) upper enable bits need write enable set
// (R17) re-enabling tx interrupt raises nothing new
// (R18) loopback feeds control bits into cts, dsr
// (R19) host reads status to find changed input
// (R20) modem interrupt pends while any flag set
`timescale 1ns/1ps

module modem_status_irq_enable
  import modem_irq_pkg::*;
#(
  parameter int APB_AW = 8
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [APB_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // active-low modem inputs from pins
  input wire logic CTS_N_I,
  input wire logic DSR_N_I,
  input wire logic RI_N_I,
  input wire logic CD_N_I,
  // interrupt sources from the rest of the channel, same clock
  input wire logic RX_DATA_READY_I,
  input wire logic RX_LINE_ERR_I,
  input wire logic TX_BELOW_THRESH_I,
  input wire logic TX_HOLD_WRITE_I,
  input wire logic XOFF_DETECT_I,
  input wire logic RTS_N_I,
  // outputs
  output logic IRQ_N_O,
  output logic SLEEP_EN_O
);

  // the decoder reads the low byte of the address, so narrower buses cannot be served
  if (APB_AW < 8 || APB_AW > 32) begin : g_bad_aw
    $error("APB_AW must be between 8 and 32");
  end

  bank_state_t s_r;
  bank_state_t s_nxt;

  logic [7:0] addr8;
  logic setup;
  logic access;
  logic wr_acc;
  logic rd_setup;
  logic hit;
  logic modem_pins;
  logic loopback;
  logic [3:0] line_now;
  logic [3:0] line_chg;
  logic ri_pin_rise;
  logic [3:0] delta_clr;
  logic [2:0] evt_clr;
  logic [2:0] evt_set;
  logic [7:0] ier_wr;
  logic [7:0] mcr_wr;
  logic irq_pending;
  logic [7:0] msr_view;

  assign addr8 = PADDR_I[7:0];
  assign setup = PSEL_I && !PENABLE_I;
  assign access = PSEL_I && PENABLE_I;
  assign wr_acc = access && PWRITE_I;
  assign rd_setup = setup && !PWRITE_I;

  always_comb begin
    hit = 1'b0;
    if (APB_AW > 8 && |(PADDR_I >> 8)) begin
      hit = 1'b0;
    end else begin
      case (addr8)
        IRQ_ENABLE_OFS, MODEM_STATUS_OFS, ENH_FEATURE_OFS,
        MODEM_CONTROL_OFS, PIN_FUNCTION_OFS, EVENT_STATUS_OFS: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // modem pin assignment and loopback select the effective line levels
  assign modem_pins = s_r.pfs[PF_MODEM_HI] || s_r.pfs[PF_MODEM_LO];
  assign loopback = s_r.modem_control_reg[MC_LOOPBACK];

  always_comb begin
    // true-sense levels; cd, ri, dsr read inactive unless assigned as modem inputs, cts is read regardless; loopback overrides cts and dsr
    line_now[LN_CD] = modem_pins && !s_r.sync2[LN_CD]; // R1 R5
    line_now[LN_RI] = modem_pins && !s_r.sync2[LN_RI]; // R2 R5
    line_now[LN_DSR] = modem_pins && !s_r.sync2[LN_DSR]; // R3 R5
    line_now[LN_CTS] = !s_r.sync2[LN_CTS]; // R4
    if (loopback) begin
      line_now[LN_CTS] = s_r.modem_control_reg[MC_RTS]; // R18
      line_now[LN_DSR] = s_r.modem_control_reg[MC_DTR]; // R18
    end
  end

  assign line_chg = line_now ^ s_r.line_prev;
  // ri pin going low to high is the true-sense ri falling
  assign ri_pin_rise = s_r.line_prev[LN_RI] && !line_now[LN_RI]; // R7

  always_comb begin
    msr_view = 8'h00;
    msr_view[MS_CD] = line_now[LN_CD]; // R1
    msr_view[MS_RI] = line_now[LN_RI]; // R2
    msr_view[MS_DSR] = line_now[LN_DSR]; // R3
    msr_view[MS_CTS] = line_now[LN_CTS]; // R4
    msr_view[MS_DCD] = s_r.delta[LN_CD];
    msr_view[MS_DRI] = s_r.delta[LN_RI];
    msr_view[MS_DDSR] = s_r.delta[LN_DSR];
    msr_view[MS_DCTS] = s_r.delta[LN_CTS];
  end

  // only the flags returned by the read are cleared, so an edge landing between
  // setup and access survives instead of vanishing unseen
  assign delta_clr = (access && !PWRITE_I && addr8 == MODEM_STATUS_OFS) ? s_r.prdata[3:0] : 4'h0; // R6 R19
  assign evt_clr = (access && !PWRITE_I && addr8 == EVENT_STATUS_OFS) ? s_r.prdata[2:0] : 3'h0;

  always_comb begin
    evt_set = 3'h0;
    evt_set[EV_XOFF] = XOFF_DETECT_I; // R10
    evt_set[EV_CTS_RISE] = s_r.cts_prev && !line_now[LN_CTS]; // R9
    evt_set[EV_RTS_RISE] = !s_r.rts_prev && RTS_N_I; // R9
  end

  // protected bits keep their value unless the enhanced write enable is set
  always_comb begin
    ier_wr = PWDATA_I[7:0];
    mcr_wr = PWDATA_I[7:0];
    if (!s_r.enhanced_feature_reg[EF_WRITE_EN]) begin
      ier_wr = (PWDATA_I[7:0] & ~IE_PROTECTED_MASK) | (s_r.interrupt_enables & IE_PROTECTED_MASK); // R16
      mcr_wr = (PWDATA_I[7:0] & ~MC_PROTECTED_MASK) | (s_r.modem_control_reg & MC_PROTECTED_MASK);
    end
  end

  always_comb begin
    irq_pending = 1'b0;
    if (s_r.interrupt_enables[IE_RXH] && RX_DATA_READY_I) irq_pending = 1'b1; // R15
    if (s_r.interrupt_enables[IE_TXH] && s_r.thr_pend) irq_pending = 1'b1; // R14
    if (s_r.interrupt_enables[IE_LINE] && RX_LINE_ERR_I) irq_pending = 1'b1; // R13
    if (s_r.interrupt_enables[IE_MODEM] && |s_r.delta) irq_pending = 1'b1; // R12 R20
    if (s_r.interrupt_enables[IE_XOFF] && s_r.evt[EV_XOFF]) irq_pending = 1'b1; // R10
    if (s_r.interrupt_enables[IE_RTS] && s_r.evt[EV_RTS_RISE]) irq_pending = 1'b1; // R9
    if (s_r.interrupt_enables[IE_CTS] && s_r.evt[EV_CTS_RISE]) irq_pending = 1'b1; // R9
  end

  always_comb begin
    s_nxt = s_r;
    // pin synchronisers
    s_nxt.sync1 = {CD_N_I, RI_N_I, DSR_N_I, CTS_N_I};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.line_prev = line_now;
    s_nxt.cts_prev = line_now[LN_CTS];
    s_nxt.rts_prev = RTS_N_I;
    s_nxt.tx_low_prev = TX_BELOW_THRESH_I;

    // change flags: a new edge wins over a clear in the same cycle
    s_nxt.delta = s_r.delta & ~delta_clr; // R6
    s_nxt.delta[LN_CD] = s_nxt.delta[LN_CD] | line_chg[LN_CD]; // R6
    s_nxt.delta[LN_DSR] = s_nxt.delta[LN_DSR] | line_chg[LN_DSR]; // R6
    s_nxt.delta[LN_CTS] = s_nxt.delta[LN_CTS] | line_chg[LN_CTS]; // R6
    s_nxt.delta[LN_RI] = s_nxt.delta[LN_RI] | ri_pin_rise; // R7
    s_nxt.evt = (s_r.evt & ~evt_clr) | evt_set;

    // tx holding interrupt follows the edge into below-threshold, not the level,
    // so setting the enable again over a low level raises nothing
    if (TX_HOLD_WRITE_I || !TX_BELOW_THRESH_I) begin
      s_nxt.thr_pend = 1'b0;
    end
    if (TX_BELOW_THRESH_I && !s_r.tx_low_prev) begin
      s_nxt.thr_pend = 1'b1; // R17
    end

    if (wr_acc) begin
      case (addr8)
        IRQ_ENABLE_OFS: s_nxt.interrupt_enables = ier_wr; // R9 R10 R11 R12 R13 R14 R15 R16
        ENH_FEATURE_OFS: s_nxt.enhanced_feature_reg = PWDATA_I[7:0];
        MODEM_CONTROL_OFS: s_nxt.modem_control_reg = mcr_wr;
        PIN_FUNCTION_OFS: s_nxt.pfs = PWDATA_I[7:0];
        default: ;
      endcase
    end

    // read data is captured in setup and answered with no wait state
    if (setup) begin
      s_nxt.prdata = 32'h0000_0000;
      s_nxt.pslverr = !hit;
      if (rd_setup) begin
        case (addr8)
          IRQ_ENABLE_OFS: s_nxt.prdata = {24'h00_0000, s_r.interrupt_enables};
          MODEM_STATUS_OFS: s_nxt.prdata = {24'h00_0000, msr_view}; // R19
          ENH_FEATURE_OFS: s_nxt.prdata = {24'h00_0000, s_r.enhanced_feature_reg};
          MODEM_CONTROL_OFS: s_nxt.prdata = {24'h00_0000, s_r.modem_control_reg};
          PIN_FUNCTION_OFS: s_nxt.prdata = {24'h00_0000, s_r.pfs};
          EVENT_STATUS_OFS: s_nxt.prdata = {29'h0000_0000, s_r.evt};
          default: s_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end

    s_nxt.irq_n = !irq_pending; // R8
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      s_r.sync1 <= 4'hf;
      s_r.sync2 <= 4'hf;
      s_r.line_prev <= 4'h0;
      s_r.delta <= 4'h0;
      s_r.interrupt_enables <= IRQ_ENABLE_RST;
      s_r.enhanced_feature_reg <= ENH_FEATURE_RST;
      s_r.modem_control_reg <= MODEM_CONTROL_RST;
      s_r.pfs <= PIN_FUNCTION_RST;
      s_r.evt <= 3'h0;
      s_r.cts_prev <= 1'b0;
      s_r.rts_prev <= 1'b1;
      s_r.tx_low_prev <= 1'b0;
      s_r.thr_pend <= 1'b0;
      s_r.irq_n <= 1'b1;
      s_r.prdata <= 32'h0000_0000;
      s_r.pslverr <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA_O = s_r.prdata;
  assign PSLVERR_O = access && s_r.pslverr;
  assign PREADY_O = 1'b1;
  assign IRQ_N_O = s_r.irq_n;
  assign SLEEP_EN_O = s_r.interrupt_enables[IE_SLEEP]; // R11

endmodule // modem_status_irq_enable

// File: tb/modem_peer.sv
// model of the modem side of the channel: the four active-low control lines
// assumes the bench asks for line states in true sense, order cd ri dsr cts
`timescale 1ns/1ps
module modem_peer (
  // requested line states, true sense
  input wire logic [3:0] want_i,
  // active-low pins
  output logic cd_n_o, ri_n_o, dsr_n_o, cts_n_o
);
  // lines move a few ns off the bank clock, as real pins would
  assign #3 {cd_n_o, ri_n_o, dsr_n_o, cts_n_o} = ~want_i;
endmodule // modem_peer

// File: tb/modem_status_irq_enable_sva.sv
// checker for the modem status and interrupt enable bank
// assumes it is bound to the bank and sees only its ports
`timescale 1ns/1ps
module modem_status_irq_enable_sva
  import modem_irq_pkg::*;
#(parameter int APB_AW = 8) (
  input wire logic CLK_I, RESET_I, PSEL_I, PENABLE_I, PWRITE_I,
  input wire logic [APB_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I, PRDATA_O,
  input wire logic PREADY_O, PSLVERR_O, CTS_N_I, DSR_N_I, RI_N_I, CD_N_I,
  input wire logic RX_DATA_READY_I, RX_LINE_ERR_I, TX_BELOW_THRESH_I, TX_HOLD_WRITE_I,
  input wire logic XOFF_DETECT_I, RTS_N_I, IRQ_N_O, SLEEP_EN_O
);
  // shadows of the writable bits, kept from completed writes only
  logic [7:0] ier_r, efr_r, mcr_r;
  logic [2:0] stab_r;
  logic wr, rd_st;
  assign wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  assign rd_st = PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I[7:0] == MODEM_STATUS_OFS;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ier_r <= 8'h00;
      efr_r <= 8'h00;
      mcr_r <= 8'h00;
      stab_r <= 3'h0;
    end else begin
      if (wr && PADDR_I[7:0] == ENH_FEATURE_OFS) efr_r <= PWDATA_I[7:0];
      if (wr && PADDR_I[7:0] == MODEM_CONTROL_OFS) mcr_r <= PWDATA_I[7:0];
      if (wr && PADDR_I[7:0] == IRQ_ENABLE_OFS)
        ier_r <= efr_r[EF_WRITE_EN] ? PWDATA_I[7:0] : {ier_r[7:4], PWDATA_I[3:0]};
      // cts judged only once it has settled through the synchroniser
      stab_r <= (CTS_N_I != $past(CTS_N_I)) ? 3'h0 : (stab_r == 3'h7 ? 3'h7 : stab_r + 3'h1);
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  a_sleep_bit: assert property (SLEEP_EN_O == ier_r[IE_SLEEP])
    else $error("sleep enable differs from enable bit 4");
  a_rx_irq: assert property (ier_r[IE_RXH] && RX_DATA_READY_I |=> !IRQ_N_O)
    else $error("receive holding interrupt missing");
  a_line_irq: assert property (ier_r[IE_LINE] && RX_LINE_ERR_I |=> !IRQ_N_O)
    else $error("line status interrupt missing");
  a_idle_irq: assert property (ier_r == 8'h00 |=> IRQ_N_O)
    else $error("interrupt with nothing enabled");
  a_tx_irq: assert property (ier_r[IE_TXH] && $rose(TX_BELOW_THRESH_I) && !TX_HOLD_WRITE_I |-> ##[1:2] !IRQ_N_O)
    else $error("transmit holding interrupt missing");
  a_xoff_irq: assert property (ier_r[IE_XOFF] && XOFF_DETECT_I |-> ##[1:2] !IRQ_N_O)
    else $error("xoff interrupt missing");
  a_cts_level: assert property (rd_st && stab_r == 3'h7 && !mcr_r[MC_LOOPBACK] |-> PRDATA_O[MS_CTS] == !CTS_N_I)
    else $error("cts status bit not the pin complement");
  a_loop_cts: assert property (rd_st && mcr_r[MC_LOOPBACK] |-> PRDATA_O[MS_CTS] == mcr_r[MC_RTS])
    else $error("loopback cts bit not the rts control bit");
endmodule // modem_status_irq_enable_sva
bind modem_status_irq_enable modem_status_irq_enable_sva #(.APB_AW(APB_AW)) chk (.*);

// File: tb/modem_status_irq_enable_test.sv
// self-checking bench for the modem status and interrupt enable bank
// assumes the package, the bank, its checker and the modem model compiled first
`timescale 1ns/1ps
module modem_status_irq_enable_test
  import modem_irq_pkg::*;
;
  typedef struct packed {logic [3:0] ln; logic wr; logic [7:0] a, d, x; logic e;} row_t;
  logic CLK_I = 1'h0, RESET_I = 1'h1, PSEL_I = 1'h0, PENABLE_I = 1'h0, PWRITE_I = 1'h0;
  logic [7:0] PADDR_I = 8'h00;
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O, r;
  logic PREADY_O, PSLVERR_O, CTS_N_I, DSR_N_I, RI_N_I, CD_N_I, IRQ_N_O, SLEEP_EN_O, e;
  logic RX_DATA_READY_I = 1'h0, RX_LINE_ERR_I = 1'h0, TX_BELOW_THRESH_I = 1'h0;
  logic TX_HOLD_WRITE_I = 1'h0, XOFF_DETECT_I = 1'h0, RTS_N_I = 1'h1;
  logic [3:0] want = 4'h0;
  int n_fail = 0, samples_checked = 0;
  // line states are cd ri dsr cts; each row waits for the synchroniser first
  row_t rows [27] = '{
    '{4'h0,1'h0,8'h00,8'h00,8'h00,1'h0}, '{4'h0,1'h0,8'h04,8'h00,8'h00,1'h0},
    '{4'h0,1'h0,8'h08,8'h00,8'h00,1'h0}, '{4'h0,1'h0,8'h0c,8'h00,8'h00,1'h0},
    '{4'h0,1'h0,8'h10,8'h00,8'h00,1'h0}, '{4'h0,1'h0,8'h14,8'h00,8'h00,1'h0},
    '{4'h0,1'h1,8'h00,8'hff,8'h00,1'h0}, '{4'h0,1'h0,8'h00,8'h00,8'h0f,1'h0},
    '{4'h0,1'h1,8'h08,8'h10,8'h00,1'h0}, '{4'h0,1'h1,8'h00,8'hff,8'h00,1'h0},
    '{4'h0,1'h0,8'h00,8'h00,8'hff,1'h0}, '{4'h0,1'h1,8'h08,8'h00,8'h00,1'h0},
    '{4'h0,1'h1,8'h00,8'h00,8'h00,1'h0}, '{4'h0,1'h0,8'h00,8'h00,8'hf0,1'h0},
    '{4'h0,1'h1,8'h08,8'h10,8'h00,1'h0}, '{4'h0,1'h1,8'h00,8'h00,8'h00,1'h0},
    '{4'h0,1'h0,8'h24,8'h00,8'h00,1'h1}, '{4'h0,1'h1,8'h10,8'h02,8'h00,1'h0},
    '{4'h1,1'h0,8'h04,8'h00,8'h11,1'h0}, '{4'h1,1'h0,8'h04,8'h00,8'h10,1'h0},
    '{4'hb,1'h0,8'h04,8'h00,8'hba,1'h0}, '{4'hb,1'h0,8'h04,8'h00,8'hb0,1'h0},
    '{4'hf,1'h0,8'h04,8'h00,8'hf0,1'h0}, '{4'hb,1'h0,8'h04,8'h00,8'hb4,1'h0},
    '{4'hb,1'h0,8'h04,8'h00,8'hb0,1'h0}, '{4'h0,1'h0,8'h04,8'h00,8'h0b,1'h0},
    '{4'h0,1'h0,8'h04,8'h00,8'h00,1'h0}};
  modem_status_irq_enable #(.APB_AW(8)) DUT (.CLK_I, .RESET_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
    .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .CTS_N_I, .DSR_N_I, .RI_N_I, .CD_N_I,
    .RX_DATA_READY_I, .RX_LINE_ERR_I, .TX_BELOW_THRESH_I, .TX_HOLD_WRITE_I, .XOFF_DETECT_I,
    .RTS_N_I, .IRQ_N_O, .SLEEP_EN_O);
  modem_peer peer (.want_i(want), .cd_n_o(CD_N_I), .ri_n_o(RI_N_I), .dsr_n_o(DSR_N_I), .cts_n_o(CTS_N_I));
  initial begin
    forever #4 CLK_I = ~CLK_I;
  end
  task automatic stop_test();
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, x);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    PSEL_I <= 1'h1;
    PENABLE_I <= 1'h0;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= {24'h0, d};
    @(posedge CLK_I);
    PENABLE_I <= 1'h1;
    do @(posedge CLK_I); while (PREADY_O !== 1'h1);
    r = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I <= 1'h0;
    PENABLE_I <= 1'h0;
  endtask
  initial begin
    #20000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge CLK_I);
    RESET_I <= 1'h0;
    foreach (rows[i]) begin
      want <= rows[i].ln;
      idle(6);
      xfer(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(r, {24'h0, rows[i].x});
      chk(32'(e), 32'(rows[i].e));
    end
    xfer(1'h1, 8'h00, 8'h08);
    want <= 4'h1;
    idle(6);
    chk(32'(IRQ_N_O), 32'h0);
    xfer(1'h0, 8'h04, 8'h00);
    idle(2);
    chk(32'(IRQ_N_O), 32'h1);
    xfer(1'h1, 8'h00, 8'h80);
    want <= 4'h0;
    idle(6);
    chk(32'(IRQ_N_O), 32'h0);
    xfer(1'h0, 8'h14, 8'h00);
    chk(r, 32'h2);
    xfer(1'h1, 8'h00, 8'h40);
    RTS_N_I <= 1'h0;
    idle(2);
    RTS_N_I <= 1'h1;
    idle(4);
    chk(32'(IRQ_N_O), 32'h0);
    xfer(1'h0, 8'h14, 8'h00);
    chk(r, 32'h4);
    xfer(1'h1, 8'h00, 8'h05);
    RX_DATA_READY_I <= 1'h1;
    idle(3);
    chk(32'(IRQ_N_O), 32'h0);
    RX_DATA_READY_I <= 1'h0;
    RX_LINE_ERR_I <= 1'h1;
    idle(3);
    chk(32'(IRQ_N_O), 32'h0);
    RX_LINE_ERR_I <= 1'h0;
    idle(3);
    chk(32'(IRQ_N_O), 32'h1);
    xfer(1'h1, 8'h00, 8'h02);
    TX_BELOW_THRESH_I <= 1'h1;
    idle(3);
    chk(32'(IRQ_N_O), 32'h0);
    TX_HOLD_WRITE_I <= 1'h1;
    idle(1);
    TX_HOLD_WRITE_I <= 1'h0;
    idle(3);
    chk(32'(IRQ_N_O), 32'h1);
    // level still high: a fresh enable must not count as a new crossing
    xfer(1'h1, 8'h00, 8'h00);
    xfer(1'h1, 8'h00, 8'h02);
    idle(3);
    chk(32'(IRQ_N_O), 32'h1);
    xfer(1'h1, 8'h00, 8'h20);
    XOFF_DETECT_I <= 1'h1;
    idle(1);
    XOFF_DETECT_I <= 1'h0;
    idle(3);
    chk(32'(IRQ_N_O), 32'h0);
    xfer(1'h0, 8'h14, 8'h00);
    chk(r, 32'h1);
    xfer(1'h1, 8'h00, 8'h10);
    idle(1);
    chk(32'(SLEEP_EN_O), 32'h1);
    xfer(1'h1, 8'h0c, 8'h12);
    xfer(1'h0, 8'h04, 8'h00);
    chk(32'(r[7:4]), 32'h1);
    xfer(1'h1, 8'h0c, 8'h11);
    xfer(1'h0, 8'h04, 8'h00);
    chk(32'(r[7:4]), 32'h2);
    RESET_I <= 1'h1;
    repeat (2) @(posedge CLK_I);
    RESET_I <= 1'h0;
    xfer(1'h0, 8'h00, 8'h00);
    chk(r, 32'h0);
    stop_test();
  end
endmodule // modem_status_irq_enable_test
